/* bench/spr_host_model.sv */
module spr_host_model
(
   output logic            sck,
   output logic            cs_b,
   output logic [3:0]      hout,
   output logic [3:0]      hoe,
   input  wire logic [3:0] line
);
   timeunit 1ns;
   timeprecision 100ps;

   logic       mode3;
   logic       wp;
   logic [7:0] rd;
   logic [7:0] rq;
   logic [3:0] rh;

   initial
   begin
      mode3 = 1'b0;
      wp    = 1'b1;
      sck   = 1'b0;
      cs_b  = 1'b1;
      hout  = 4'hf;
      hoe   = 4'hc;
      rd    = 8'h00;
      rq    = 8'h00;
      rh    = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // fall to fall
   // one group per 80 ns period: set while low, taken on the rise
   task automatic beat(input logic [3:0] v, input logic [3:0] en);
      sck  = 1'b0;
      hout = v;
      hoe  = en;
      #40;
      sck = 1'b1;
      rd  = {rd[6:0], line[1]};
      rq  = {rq[3:0], line};
      #20;
      // double rate shows the low nibble while the clock is high
      rh = line;
      #20;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // idle level, select first
   // single mode: one bit only on line zero
   task automatic frame(input logic [7:0] b[$], input logic q);
      sck = mode3;
      #13;
      cs_b = 1'b0;
      #20;
      foreach (b[i])
      begin
         if (q && i > 0)
         begin
            beat(b[i][7:4], 4'hf);
            beat(b[i][3:0], 4'hf);
         end
         else
            for (int k = 7; k >= 0; k--)
               beat({1'b1, wp, 1'b0, b[i][k]}, 4'hd);
      end
      #20;
      sck = mode3;
      // line three driven high on deselect
      hout = {1'b1, wp, 2'b11};
      hoe  = 4'hc;
      #20;
      cs_b = 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // deselected, line three low
   task automatic pulse_low(input int ns);
      hout[3] = 1'b0;
      #(ns);
      hout[3] = 1'b1;
   endtask
endmodule

/* bench/spr_tb_top.sv */
`include "spr_params.svh"

module spr_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic       clk = 1'b0;
   logic       rst_b;
   logic       qe;
   logic       re;
   logic       swd;
   logic       rdm;
   logic       ddr;
   logic [7:0] tx;
   logic       rx_ready;
   logic [3:0] dout;
   logic [3:0] oe_b;
   logic       rx_valid;
   logic [7:0] rx_data;
   logic       rx_first;
   logic       rx_drop;
   logic       exec;
   logic [7:0] op;
   logic       hw_reset;
   logic       sck;
   logic       cs_b;
   logic [3:0] hout;
   logic [3:0] hoe;
   wire  [3:0] line;
   int         n_fail = 0;
   int         compares = 0;
   int         n_exec = 0;
   int         n_rst = 0;
   int         n_drop = 0;
   int         n_hold = 0;
   logic [8:0] got[$];

   always #12.5 clk = ~clk;

   // undriven lines 0 and 1 toggle so a stale value never passes
   assign line = (~oe_b & dout) | (oe_b & hoe & hout) | (oe_b & ~hoe & {2'b11, {2{~sck}}});

   spr_top dut (.CLK(clk), .RST_B(rst_b), .SCK(sck), .CS_B(cs_b), .QUAD_LINE_IN(line),
      .QUAD_LINE_OUT(dout), .QUAD_LINE_OE_B(oe_b), .QUAD_ENABLE(qe), .RESET_ENABLE(re),
      .STATUS_WRITE_DISABLE_NV(swd), .READ_MODE(rdm), .DDR_MODE(ddr), .TX_DATA(tx),
      .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data), .RX_FIRST(rx_first),
      .RX_DROP(rx_drop), .REG_WRITE_EXEC(exec), .REG_WRITE_OP(op), .HW_RESET(hw_reset));

   spr_host_model host (.sck(sck), .cs_b(cs_b), .hout(hout), .hoe(hoe), .line(line));

   always @(posedge clk)
   begin
      n_exec += (exec === 1'b1);
      n_rst += (hw_reset === 1'b1);
      n_drop += (rx_drop === 1'b1);
      n_hold += (cs_b === 1'b1 && oe_b[3] === 1'b0 && dout[3] === 1'b1);
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
         got.push_back({rx_first, rx_data});
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      if (n_fail == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic settle;
      repeat (24) @(posedge clk);
      #2;
   endtask

   task automatic clr;
      n_exec = 0;
      n_rst = 0;
      n_drop = 0;
      n_hold = 0;
      got.delete();
   endtask

   task automatic cfg(input logic q, input logic r, input logic s, input logic w);
      qe = q;
      re = r;
      swd = s;
      host.wp = w;
      clr();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic s_wrr;
      logic [3:0] t[4];
      t = '{4'b1000, 4'b0001, 4'b1101, 4'b1011};
      foreach (t[i])
      begin
         cfg(t[i][1], 1'b0, t[i][3], t[i][2]);
         host.frame({`SPR_OP_WRITE_REGS, 8'h5a}, t[i][1]);
         settle();
         chk(n_exec, t[i][0]);
      end
      chk(op, `SPR_OP_WRITE_REGS);
   endtask

   task automatic s_write_any_register_cmd;
      logic [23:0] a[5];
      a = '{`SPR_ADDR_S1NV, `SPR_ADDR_S1V, `SPR_ADDR_C1NV, `SPR_ADDR_C1V, 24'h000004};
      foreach (a[i])
      begin
         cfg(1'b0, 1'b0, 1'b1, 1'b0);
         host.frame({`SPR_OP_WRITE_ANY, a[i][23:16], a[i][15:8], a[i][7:0], 8'h3c}, 1'b0);
         settle();
         chk(n_exec, i == 4);
      end
      chk(op, `SPR_OP_WRITE_ANY);
   endtask

   task automatic s_rx(input logic m3, input logic q);
      cfg(q, 1'b0, 1'b0, 1'b1);
      host.mode3 = m3;
      host.frame({8'h02, 8'hc3, 8'h96}, q);
      settle();
      chk(got.size(), 3);
      chk(got[0], 9'h102);
      chk(got[1], 9'h0c3);
      chk(got[2], 9'h096);
      chk(n_hold, 0);
   endtask

   task automatic s_read(input logic q, input logic d);
      cfg(q, 1'b0, 1'b0, 1'b1);
      rdm = 1'b1;
      ddr = d;
      tx = {q, d, 6'h25};
      host.frame({8'h0b, 8'h00}, q);
      settle();
      if (!q)
         chk(host.rd, tx);
      else if (!d)
         chk(host.rq, tx);
      else
         chk({host.rq[3:0], host.rh}, tx);
      chk(n_hold, 2);
      chk(oe_b, 4'hf);
      rdm = 1'b0;
      ddr = 1'b0;
   endtask

   task automatic s_rst;
      int         w[4];
      logic [2:0] e[4];
      w = '{300, 300, 100, 300};
      e = '{3'b011, 3'b111, 3'b010, 3'b000};
      foreach (w[i])
      begin
         cfg(e[i][2], e[i][1], 1'b0, 1'b1);
         host.pulse_low(w[i]);
         settle();
         chk(n_rst, e[i][0]);
      end
      // selected quad traffic holds line three low well past the pulse time
      cfg(1'b1, 1'b1, 1'b0, 1'b1);
      host.frame({8'h02, 8'h00, 8'h00}, 1'b1);
      settle();
      chk(n_rst, 0);
   endtask

   task automatic s_fifo;
      logic [7:0] b[$];
      int         k;
      cfg(1'b0, 1'b0, 1'b0, 1'b1);
      rx_ready = 1'b0;
      b = {8'h02};
      for (int i = 0; i < 34; i++)
         b.push_back(8'(i));
      host.frame(b, 1'b0);
      settle();
      chk(rx_valid, 1'b1);
      rx_ready = 1'b1;
      k = 0;
      while (rx_valid === 1'b1 && k < 64)
      begin
         @(posedge clk);
         #2;
         k++;
      end
      if (k == 64)
      begin
         n_fail++;
         end_sim();
      end
      chk(got.size() + n_drop, 35);
      chk(n_drop > 0, 1'b1);
      chk(got[0], 9'h102);
      chk(got[31], 9'h01e);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_b = 1'b0;
      qe = 1'b0;
      re = 1'b0;
      swd = 1'b0;
      rdm = 1'b0;
      ddr = 1'b0;
      tx = 8'h00;
      rx_ready = 1'b1;
      repeat (5) @(posedge clk);
      #2;
      rst_b = 1'b1;
      settle();
      s_wrr();
      s_write_any_register_cmd();
      s_rx(1'b0, 1'b0);
      s_rx(1'b1, 1'b1);
      s_read(1'b0, 1'b0);
      s_read(1'b1, 1'b0);
      s_read(1'b1, 1'b1);
      s_rst();
      s_fifo();
      end_sim();
   end
endmodule

/* shared/spr_params.svh */
`ifndef SPR_PARAMS_SVH
`define SPR_PARAMS_SVH
`define SPR_CLK_MHZ        40
`define SPR_RESET_PULSE_NS 200
`define SPR_DESELECT_NS    50
`define SPR_OP_WRITE_REGS  8'h01
`define SPR_OP_WRITE_ANY   8'h71
`define SPR_ADDR_S1NV      24'h000000
`define SPR_ADDR_S1V       24'h800000
`define SPR_ADDR_C1NV      24'h000002
`define SPR_ADDR_C1V       24'h800002
`define SPR_BYTE_BITS      4'h8
`define SPR_ADDR_BYTES     2'h3
`define SPR_FIFO_DEPTH     32
`define SPR_LINES          4
`endif

/* shared/spr_pkg.sv */
package spr_pkg;
   typedef enum logic [1:0]
   {
      SPR_OPCODE = 2'b00,
      SPR_ADDR   = 2'b01,
      SPR_DATA   = 2'b10
   } spr_frame_t;
endpackage

/* verilog/spr_fifo.sv */
module spr_fifo
#(
   parameter int W = 9,
   parameter int D = 32
)
(
   input  wire logic         CLK,
   input  wire logic         RST_B,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic          do_wr;
   logic          do_rd;

   assign in_ready  = (count != D[AW:0]);
   assign out_valid = (count != '0);
   assign do_wr     = in_valid && in_ready;
   assign do_rd     = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge CLK)
   begin
      if (do_wr)
         mem[wr_ptr] <= in_data;
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (do_wr)
            wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
         if (do_rd)
            rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule

/* verilog/spr_top.sv */
`include "spr_params.svh"

////////////////////////////////////////////////////////////////////////////////
module spr_top
#(
   parameter int RESET_PULSE_NS = `SPR_RESET_PULSE_NS,
   parameter int DESELECT_NS    = `SPR_DESELECT_NS,
   parameter int FIFO_DEPTH     = `SPR_FIFO_DEPTH
)
(
   input  wire logic                  CLK,
   input  wire logic                  RST_B,
   input  wire logic                  SCK,
   input  wire logic                  CS_B,
   input  wire logic [`SPR_LINES-1:0] QUAD_LINE_IN,
   output logic [`SPR_LINES-1:0]      QUAD_LINE_OUT,
   output logic [`SPR_LINES-1:0]      QUAD_LINE_OE_B,
   input  wire logic                  QUAD_ENABLE,
   input  wire logic                  RESET_ENABLE,
   input  wire logic                  STATUS_WRITE_DISABLE_NV,
   input  wire logic                  READ_MODE,
   input  wire logic                  DDR_MODE,
   input  wire logic [7:0]            TX_DATA,
   output logic                       RX_VALID,
   input  wire logic                  RX_READY,
   output logic [7:0]                 RX_DATA,
   output logic                       RX_FIRST,
   output logic                       RX_DROP,
   output logic                       REG_WRITE_EXEC,
   output logic [7:0]                 REG_WRITE_OP,
   output logic                       HW_RESET
);
   localparam int RP_CYC  = (RESET_PULSE_NS * `SPR_CLK_MHZ + 999) / 1000;
   localparam int DS_CYC0 = (DESELECT_NS * `SPR_CLK_MHZ) / 1000;
   localparam int DS_CYC  = (DS_CYC0 < 1) ? 1 : DS_CYC0;

   ////////////////////////////////////////////////////////////////////////////
   // link side, clocked by SCK; all but the byte toggle and byte are cleared by deselect
   logic       link_rst_b;
   logic [7:0] shift_in;
   logic [3:0] bit_cnt;
   logic       past_opcode;
   logic [7:0] byte_hold;
   logic       byte_tgl;
   logic       drive_en;
   logic [2:0] fall_cnt;
   logic [3:0] fall_val;
   logic [3:0] rise_val;
   logic       drove;
   logic       quad_rx;
   logic [3:0] next_shift;
   logic       byte_done;
   logic [7:0] byte_next;

   // deselect ends every frame; no SCK edge is needed to clear the link side
   assign link_rst_b = RST_B && !CS_B;
   assign quad_rx    = QUAD_ENABLE && past_opcode;

   always_comb
   begin
      next_shift = quad_rx ? 4'h4 : 4'h1;
      byte_done  = (bit_cnt + next_shift == `SPR_BYTE_BITS);
      byte_next  = quad_rx ? {shift_in[3:0], QUAD_LINE_IN} : {shift_in[6:0], QUAD_LINE_IN[0]};
   end

   always_ff @(posedge SCK or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         shift_in    <= 8'h00;
         bit_cnt     <= 4'h0;
         past_opcode <= 1'b0;
      end
      else
      begin
         shift_in <= byte_next;
         if (byte_done)
         begin
            bit_cnt     <= 4'h0;
            past_opcode <= 1'b1;
         end
         else
            bit_cnt <= bit_cnt + next_shift;
      end
   end

   // toggle and byte survive deselect: clearing them there would fake a byte
   always_ff @(posedge SCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         byte_tgl  <= 1'b0;
         byte_hold <= 8'h00;
      end
      else if (byte_done && !CS_B)
      begin
         byte_tgl  <= !byte_tgl;
         byte_hold <= byte_next;
      end
   end

   // falling edges count cycles after the opcode byte in read mode
   always_ff @(negedge SCK or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         drive_en <= 1'b0;
         fall_cnt <= 3'h0;
         fall_val <= 4'h0;
      end
      else
      begin
         drive_en <= READ_MODE && past_opcode;
         if (READ_MODE && past_opcode)
         begin
            fall_cnt <= fall_cnt + 3'h1;
            if (!QUAD_ENABLE)
               fall_val <= {2'b00, TX_DATA[3'h7 - fall_cnt], 1'b0};
            else if (DDR_MODE || !fall_cnt[0])
               fall_val <= TX_DATA[7:4];
            else
               fall_val <= TX_DATA[3:0];
         end
      end
   end

   // double rate also updates on rising edges
   always_ff @(posedge SCK or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         rise_val <= 4'h0;
         drove    <= 1'b0;
      end
      else
      begin
         rise_val <= TX_DATA[3:0];
         if (drive_en)
            drove <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core side crossings
   logic       cs_s1, cs_s2, cs_s3;
   logic       l3_s1, l3_s2;
   logic       l2_s1, l2_s2;
   logic       tg_s1, tg_s2, tg_s3;
   logic       dr_s1, dr_s2;
   logic       byte_evt;
   logic       frame_end;
   logic       drove_seen;

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         {cs_s1, cs_s2, cs_s3} <= 3'h7;
         {l3_s1, l3_s2}        <= 2'h3;
         {l2_s1, l2_s2}        <= 2'h3;
         {tg_s1, tg_s2, tg_s3} <= 3'h0;
         {dr_s1, dr_s2}        <= 2'h0;
      end
      else
      begin
         {cs_s1, cs_s2, cs_s3} <= {CS_B, cs_s1, cs_s2};
         {l3_s1, l3_s2}        <= {QUAD_LINE_IN[3], l3_s1};
         {l2_s1, l2_s2}        <= {QUAD_LINE_IN[2], l2_s1};
         {tg_s1, tg_s2, tg_s3} <= {byte_tgl, tg_s1, tg_s2};
         {dr_s1, dr_s2}        <= {drove, dr_s1};
      end
   end

   assign byte_evt  = tg_s2 ^ tg_s3;
   assign frame_end = cs_s2 && !cs_s3;

   // the link side forgets that it drove once deselected, so remember it here
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         drove_seen <= 1'b0;
      else if (frame_end)
         drove_seen <= 1'b0;
      else if (dr_s2)
         drove_seen <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // command tracking and write protection
   spr_pkg::spr_frame_t frame_st;
   logic [7:0]  opcode;
   logic [23:0] addr;
   logic [1:0]  addr_cnt;
   logic        first_pend;
   logic        pend;
   logic [8:0]  pend_word;
   logic        fifo_ready;
   logic        protect;
   logic        prot_target;

   // quad mode disables the protect function
   assign protect     = !QUAD_ENABLE && !l2_s2 && STATUS_WRITE_DISABLE_NV;
   assign prot_target = (addr == `SPR_ADDR_S1NV) || (addr == `SPR_ADDR_S1V)
                     || (addr == `SPR_ADDR_C1NV) || (addr == `SPR_ADDR_C1V);

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         frame_st   <= spr_pkg::SPR_OPCODE;
         opcode     <= 8'h00;
         addr       <= 24'h000000;
         addr_cnt   <= 2'h0;
         first_pend <= 1'b1;
      end
      else if (frame_end)
      begin
         frame_st   <= spr_pkg::SPR_OPCODE;
         addr_cnt   <= 2'h0;
         first_pend <= 1'b1;
      end
      else if (byte_evt)
      begin
         first_pend <= 1'b0;
         case (frame_st)
            spr_pkg::SPR_OPCODE:
            begin
               opcode   <= byte_hold;
               frame_st <= (byte_hold == `SPR_OP_WRITE_ANY) ? spr_pkg::SPR_ADDR : spr_pkg::SPR_DATA;
            end
            spr_pkg::SPR_ADDR:
            begin
               addr     <= {addr[15:0], byte_hold};
               addr_cnt <= addr_cnt + 2'h1;
               if (addr_cnt + 2'h1 == `SPR_ADDR_BYTES)
                  frame_st <= spr_pkg::SPR_DATA;
            end
            default:
               frame_st <= spr_pkg::SPR_DATA;
         endcase
      end
   end

   // protected writes end without execution or error
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         REG_WRITE_EXEC <= 1'b0;
         REG_WRITE_OP   <= 8'h00;
      end
      else
      begin
         REG_WRITE_EXEC <= 1'b0;
         if (frame_end && frame_st == spr_pkg::SPR_DATA)
         begin
            if (opcode == `SPR_OP_WRITE_REGS)
               REG_WRITE_EXEC <= !protect;
            else if (opcode == `SPR_OP_WRITE_ANY)
               REG_WRITE_EXEC <= !(protect && prot_target);
            REG_WRITE_OP <= opcode;
         end
      end
   end

   // a byte waits here while the fifo is full; a second arrival is dropped
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         pend      <= 1'b0;
         pend_word <= 9'h000;
         RX_DROP   <= 1'b0;
      end
      else
      begin
         RX_DROP <= byte_evt && pend && !fifo_ready;
         if (byte_evt && !(pend && !fifo_ready))
         begin
            pend      <= 1'b1;
            pend_word <= {first_pend, byte_hold};
         end
         else if (pend && fifo_ready)
            pend <= 1'b0;
      end
   end

   spr_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo
   (
      .CLK       (CLK),
      .RST_B     (RST_B),
      .in_valid  (pend),
      .in_ready  (fifo_ready),
      .in_data   (pend_word),
      .out_valid (RX_VALID),
      .out_ready (RX_READY),
      .out_data  ({RX_FIRST, RX_DATA})
   );

   ////////////////////////////////////////////////////////////////////////////
   // hardware reset sensing on line three
   logic [15:0] low_cnt;
   logic        rst_armed;
   logic [7:0]  hold_cnt;

   assign rst_armed = RESET_ENABLE && cs_s2 && !l3_s2;

   // low must last the full pulse time
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         low_cnt  <= 16'h0000;
         HW_RESET <= 1'b0;
      end
      else
      begin
         HW_RESET <= 1'b0;
         if (!rst_armed)
            low_cnt <= 16'h0000;
         else if (low_cnt != 16'(RP_CYC))
         begin
            low_cnt <= low_cnt + 16'h0001;
            HW_RESET <= (low_cnt == 16'(RP_CYC - 1));
         end
      end
   end

   // drive line three high after a read
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         hold_cnt <= 8'h00;
      else if (frame_end && (drove_seen || dr_s2))
         hold_cnt <= 8'(DS_CYC);
      else if (hold_cnt != 8'h00)
         hold_cnt <= hold_cnt - 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive
   genvar gi;
   generate
      for (gi = 0; gi < `SPR_LINES; gi++)
      begin : g_line
         logic live;
         assign live = QUAD_ENABLE ? 1'b1 : (gi == 1);
         always_comb
         begin
            QUAD_LINE_OUT[gi]  = (DDR_MODE && QUAD_ENABLE && SCK) ? rise_val[gi] : fall_val[gi];
            QUAD_LINE_OE_B[gi] = !(drive_en && !CS_B && live);
            if (gi == 3 && CS_B && hold_cnt != 8'h00)
            begin
               QUAD_LINE_OUT[gi]  = 1'b1;
               QUAD_LINE_OE_B[gi] = 1'b0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_low_held;
      rst_armed [*8];
   endsequence

   property p_reset_needs_time;
      @(posedge CLK) disable iff (!RST_B) HW_RESET |-> $past(low_cnt) == 16'(RP_CYC - 1);
   endproperty
   a_reset_needs_time: assert property (p_reset_needs_time) else $error("reset without full low");

   property p_reset_disabled;
      @(posedge CLK) disable iff (!RST_B) !RESET_ENABLE [*2] |-> !HW_RESET;
   endproperty
   a_reset_disabled: assert property (p_reset_disabled) else $error("reset while disabled");

   property p_reset_selected;
      @(posedge CLK) disable iff (!RST_B) (!cs_s2) [*2] |-> !HW_RESET;
   endproperty
   a_reset_selected: assert property (p_reset_selected) else $error("reset while selected");

   property p_reset_fires;
      @(posedge CLK) disable iff (!RST_B)
         (rst_armed && low_cnt == 16'h0000) ##1 s_low_held |-> ##[0:300] HW_RESET || !rst_armed;
   endproperty
   a_reset_fires: assert property (p_reset_fires) else $error("reset not raised");

   property p_short_ignored;
      @(posedge CLK) disable iff (!RST_B) $fell(rst_armed) |-> ##1 low_cnt == 16'h0000;
   endproperty
   a_short_ignored: assert property (p_short_ignored) else $error("low count kept");

   property p_wrr_blocked;
      @(posedge CLK) disable iff (!RST_B)
         frame_end && protect && opcode == `SPR_OP_WRITE_REGS |=> !REG_WRITE_EXEC;
   endproperty
   a_wrr_blocked: assert property (p_wrr_blocked) else $error("protected write executed");

   property p_write_any_register_cmd_blocked;
      @(posedge CLK) disable iff (!RST_B)
         frame_end && protect && prot_target && opcode == `SPR_OP_WRITE_ANY |=> !REG_WRITE_EXEC;
   endproperty
   a_write_any_register_cmd_blocked: assert property (p_write_any_register_cmd_blocked) else $error("protected write-any executed");

   property p_quad_no_protect;
      @(posedge CLK) disable iff (!RST_B)
         frame_end && QUAD_ENABLE && frame_st == spr_pkg::SPR_DATA
         && opcode == `SPR_OP_WRITE_REGS |=> REG_WRITE_EXEC;
   endproperty
   a_quad_no_protect: assert property (p_quad_no_protect) else $error("protect in quad");

   property p_line3_high;
      @(posedge CLK) disable iff (!RST_B)
         frame_end && (drove_seen || dr_s2) ##1 CS_B |-> QUAD_LINE_OUT[3] && !QUAD_LINE_OE_B[3];
   endproperty
   a_line3_high: assert property (p_line3_high) else $error("line three not driven high");
endmodule
